// ==== pam_defs.svh ====
// constants for the peripheral access matrix
`ifndef PAM_DEFS_SVH
`define PAM_DEFS_SVH

`define PAM_ADDR_W      16
`define PAM_DATA_W      32
`define PAM_GRP_W       5
`define PAM_GRP_LSB     11
`define PAM_GPIO_W      32
`define PAM_TRIG_W      8

`define PAM_GRP_FRAME1  5'h00
`define PAM_GRP_FRAME2  5'h01
`define PAM_GRP_SCI     5'h02
`define PAM_GRP_I2C     5'h03
`define PAM_GRP_CAN     5'h04
`define PAM_GRP_ADCCFG  5'h05
`define PAM_GRP_EMIF    5'h06
`define PAM_GRP_USB     5'h07
`define PAM_GRP_DEVCAP  5'h08
`define PAM_GRP_GPIOCFG 5'h09
`define PAM_GRP_ANASYS  5'h0a
`define PAM_GRP_RSTCFG  5'h0b
`define PAM_GRP_CLKPLL  5'h0c
`define PAM_GRP_SYSCFG  5'h0d
`define PAM_GRP_FLASH   5'h0e
`define PAM_GRP_TIMER   5'h0f
`define PAM_GRP_TRIGSEL 5'h10
`define PAM_GRP_GPIODAT 5'h11
`define PAM_GRP_ADCRES  5'h12

// groups under write-then-read ordering protection
`define PAM_PROT_MASK   32'h0003_ffff

// trigger bits: 0 pwm, 1 sigma-delta, 2 capture, 3 quadrature,
// 4 comparator, 5 dac, 6 adc, 7 serial
`define PAM_DMA_TRIG_MASK 8'hc3

`define PAM_GPIO_RST    32'h0000_0000
`endif

// ==== pam_pkg.sv ====
// types for the peripheral access matrix
package pam_pkg;
    typedef enum logic [1:0] {
        PAM_CPU = 2'h0,
        PAM_CLA = 2'h1,
        PAM_DMA = 2'h2
    } pam_master_t;

    typedef enum logic [1:0] {
        PAM_IDLE  = 2'h0,
        PAM_ISSUE = 2'h1,
        PAM_RESP  = 2'h3
    } pam_state_t;
endpackage

// ==== pam_gpio_if.sv ====
// carrier between the access matrix and its gpio data block
`timescale 1ns/100ps
`include "pam_defs.svh"
interface pam_gpio_if;
    logic                   wrEn;
    logic                   wrMap;
    logic                   wrCla;
    logic [`PAM_GPIO_W-1:0] wdata;
    logic [`PAM_GPIO_W-1:0] mapRd;
    logic [`PAM_GPIO_W-1:0] cpuRd;
    logic [`PAM_GPIO_W-1:0] claRd;

    modport ctrl (output wrEn, output wrMap, output wrCla, output wdata,
                  input mapRd, input cpuRd, input claRd);
    modport gpio (input wrEn, input wrMap, input wrCla, input wdata,
                  output mapRd, output cpuRd, output claRd);
endinterface

// ==== pam_gpio.sv ====
// gpio pin map and cpu and accelerator data registers
`timescale 1ns/100ps
`include "pam_defs.svh"
module pam_gpio (
    input  wire logic                   sys_clk,
    input  wire logic                   rstnSync,
    pam_gpio_if.gpio                    bus,
    output logic [`PAM_GPIO_W-1:0]      gpioOut
);
    import pam_pkg::*;

    logic [`PAM_GPIO_W-1:0] map_q, map_d;
    logic [`PAM_GPIO_W-1:0] cpuData_q, cpuData_d;
    logic [`PAM_GPIO_W-1:0] claData_q, claData_d;
    logic [`PAM_GPIO_W-1:0] pins_q, pins_d;

    always_comb begin
        map_d     = map_q;
        cpuData_d = cpuData_q;
        claData_d = claData_q;
        if (bus.wrEn) begin
            if (bus.wrMap) begin
                map_d = bus.wdata;
            end else if (bus.wrCla) begin
                claData_d = bus.wdata;
            end else begin
                cpuData_d = bus.wdata;
            end
        end
        // map bit set hands the pin to the accelerator
        pins_d = (map_q & claData_q) | (~map_q & cpuData_q); // RULE3
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            map_q     <= `PAM_GPIO_RST;
            cpuData_q <= `PAM_GPIO_RST;
            claData_q <= `PAM_GPIO_RST;
            pins_q    <= `PAM_GPIO_RST;
        end else begin
            map_q     <= map_d;
            cpuData_q <= cpuData_d;
            claData_q <= claData_d;
            pins_q    <= pins_d;
        end
    end

    assign bus.mapRd = map_q;
    assign bus.cpuRd = cpuData_q;
    assign bus.claRd = claData_q;
    assign gpioOut   = pins_q;
endmodule

// ==== peripheral_access_matrix.sv ====
// bus-master permission and routing matrix for peripheral groups
// Summary of operation
// RULE1: frame 1 and frame 2 each go wholly to one secondary master.
// RULE2: capture, quadrature, comparator and dac events never start dma transfers.
// RULE3: cpu and accelerator own gpio data registers; pin map picks the driver.
// RULE4: capability, peripheral reset and cpu select groups serve the main cpu only.
// RULE5: gpio pin map and configuration accept only main cpu accesses.
// RULE6: dma and accelerator trigger select groups serve the main cpu only.
// RULE7: clock and pll configuration reachable only by the main cpu.
// RULE8: accelerator reaches adc results and control peripheral register sets directly.
// RULE9: protected cpu read waits until the target accepts the preceding posted cpu write.
// RULE10: unpermitted access is blocked, changes nothing, and reads back zero.
`timescale 1ns/100ps
`include "pam_defs.svh"
module peripheral_access_matrix (
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    input  wire logic                       frame1ToDma,
    input  wire logic                       frame2ToDma,
    input  wire logic                       cpuReq,
    input  wire logic                       cpuWrite,
    input  wire logic [`PAM_ADDR_W-1:0]     cpuAddr,
    input  wire logic [`PAM_DATA_W-1:0]     cpuWdata,
    input  wire logic                       claReq,
    input  wire logic                       claWrite,
    input  wire logic [`PAM_ADDR_W-1:0]     claAddr,
    input  wire logic [`PAM_DATA_W-1:0]     claWdata,
    input  wire logic                       dmaReq,
    input  wire logic                       dmaWrite,
    input  wire logic [`PAM_ADDR_W-1:0]     dmaAddr,
    input  wire logic [`PAM_DATA_W-1:0]     dmaWdata,
    output logic                            cpuDone,
    output logic                            claDone,
    output logic                            dmaDone,
    output logic                            respDenied,
    output logic [`PAM_DATA_W-1:0]          respRdata,
    output logic                            tgtReq,
    output logic                            tgtWrite,
    output logic [`PAM_ADDR_W-1:0]          tgtAddr,
    output logic [`PAM_DATA_W-1:0]          tgtWdata,
    output pam_pkg::pam_master_t            tgtMaster,
    input  wire logic                       tgtAccept,
    input  wire logic [`PAM_DATA_W-1:0]     tgtRdata,
    input  wire logic [`PAM_TRIG_W-1:0]     periphTrig,
    output logic [`PAM_TRIG_W-1:0]          dmaTrig,
    output logic [`PAM_GPIO_W-1:0]          gpioOut
);
    import pam_pkg::*;

    logic                   rstnMeta_q;
    logic                   rstnSync;
    pam_state_t             st_q, st_d;
    logic [2:0]             done_q, done_d;
    logic                   denied_q, denied_d;
    logic [`PAM_DATA_W-1:0] rdata_q, rdata_d;
    logic                   tReq_q, tReq_d;
    logic                   tWr_q, tWr_d;
    logic [`PAM_ADDR_W-1:0] tAddr_q, tAddr_d;
    logic [`PAM_DATA_W-1:0] tData_q, tData_d;
    pam_master_t            tMst_q, tMst_d;
    logic                   postSel_q, postSel_d;
    logic                   postValid_q, postValid_d;
    logic [`PAM_ADDR_W-1:0] postAddr_q, postAddr_d;
    logic [`PAM_DATA_W-1:0] postData_q, postData_d;
    logic [`PAM_TRIG_W-1:0] trig_q, trig_d;

    logic                   go;
    logic                   gPost;
    logic                   gWr;
    pam_master_t            gM;
    logic [`PAM_ADDR_W-1:0] gAddr;
    logic [`PAM_DATA_W-1:0] gData;
    logic [`PAM_GRP_W-1:0]  gGrp;

    pam_gpio_if gpioBus ();

    function automatic logic [`PAM_GRP_W-1:0] grpOf(input logic [`PAM_ADDR_W-1:0] a);
        grpOf = a[`PAM_ADDR_W-1:`PAM_GRP_LSB];
    endfunction

    function automatic logic protOf(input logic [`PAM_ADDR_W-1:0] a);
        logic [31:0] m;
        m = `PAM_PROT_MASK;
        protOf = m[grpOf(a)];
    endfunction

    function automatic logic permOk(input logic [`PAM_GRP_W-1:0] g,
                                    input pam_master_t m,
                                    input logic f1Dma,
                                    input logic f2Dma);
        unique case (g)
            // a frame belongs whole to the cpu and its one secondary
            `PAM_GRP_FRAME1:  permOk = (m == PAM_CPU) ||
                                       (f1Dma ? (m == PAM_DMA) : (m == PAM_CLA)); // RULE1 RULE8
            `PAM_GRP_FRAME2:  permOk = (m == PAM_CPU) ||
                                       (f2Dma ? (m == PAM_DMA) : (m == PAM_CLA)); // RULE1
            `PAM_GRP_ADCCFG,
            `PAM_GRP_GPIODAT: permOk = (m != PAM_DMA);
            `PAM_GRP_EMIF:    permOk = (m != PAM_CLA);
            `PAM_GRP_ADCRES:  permOk = 1'b1; // RULE8
            `PAM_GRP_DEVCAP,
            `PAM_GRP_GPIOCFG,
            `PAM_GRP_TRIGSEL,
            `PAM_GRP_CLKPLL,
            `PAM_GRP_SCI,
            `PAM_GRP_I2C,
            `PAM_GRP_CAN,
            `PAM_GRP_USB,
            `PAM_GRP_ANASYS,
            `PAM_GRP_RSTCFG,
            `PAM_GRP_SYSCFG,
            `PAM_GRP_FLASH,
            `PAM_GRP_TIMER:   permOk = (m == PAM_CPU); // RULE4 RULE5 RULE6 RULE7
            default:          permOk = 1'b0;
        endcase
    endfunction

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta_q <= 1'b0;
            rstnSync   <= 1'b0;
        end else begin
            rstnMeta_q <= 1'b1;
            rstnSync   <= rstnMeta_q;
        end
    end

    always_comb begin
        st_d        = st_q;
        done_d      = 3'h0;
        denied_d    = 1'b0;
        rdata_d     = rdata_q;
        tReq_d      = tReq_q;
        tWr_d       = tWr_q;
        tAddr_d     = tAddr_q;
        tData_d     = tData_q;
        tMst_d      = tMst_q;
        postSel_d   = postSel_q;
        postValid_d = postValid_q;
        postAddr_d  = postAddr_q;
        postData_d  = postData_q;
        // event inputs of frame 1 that may not reach the dma are cut here
        trig_d      = periphTrig & `PAM_DMA_TRIG_MASK; // RULE2
        gpioBus.wrEn  = 1'b0;
        gpioBus.wrMap = 1'b0;
        gpioBus.wrCla = 1'b0;
        // default from the cpu port so the bus never reads a not yet assigned value
        gpioBus.wdata = cpuWdata;
        go    = 1'b0;
        gPost = 1'b0;
        gWr   = 1'b0;
        gM    = PAM_CPU;
        gAddr = cpuAddr;
        gData = cpuWdata;
        gGrp  = grpOf(gAddr);
        unique case (st_q)
            PAM_IDLE: begin
                // a protected read must not overtake the posted write
                if (cpuReq && !cpuWrite && !(postValid_q && protOf(cpuAddr))) begin // RULE9
                    go = 1'b1;
                end else if (cpuReq && cpuWrite && !postValid_q) begin
                    // posting frees the cpu; denied writes never reach the slot
                    done_d[PAM_CPU] = 1'b1;
                    st_d            = PAM_RESP;
                    rdata_d         = '0;
                    if (permOk(grpOf(cpuAddr), PAM_CPU, frame1ToDma, frame2ToDma)) begin
                        postValid_d = 1'b1;
                        postAddr_d  = cpuAddr;
                        postData_d  = cpuWdata;
                    end else begin
                        denied_d = 1'b1; // RULE10
                    end
                end else if (postValid_q) begin
                    go    = 1'b1;
                    gPost = 1'b1;
                    gWr   = 1'b1;
                    gAddr = postAddr_q;
                    gData = postData_q;
                end else if (claReq) begin
                    go    = 1'b1;
                    gM    = PAM_CLA;
                    gWr   = claWrite;
                    gAddr = claAddr;
                    gData = claWdata;
                end else if (dmaReq) begin
                    go    = 1'b1;
                    gM    = PAM_DMA;
                    gWr   = dmaWrite;
                    gAddr = dmaAddr;
                    gData = dmaWdata;
                end
                gGrp          = grpOf(gAddr);
                gpioBus.wdata = gData;
                if (go) begin
                    if (!permOk(gGrp, gM, frame1ToDma, frame2ToDma)) begin
                        done_d[gM] = 1'b1; // RULE10
                        denied_d   = 1'b1;
                        rdata_d    = '0;
                        st_d       = PAM_RESP;
                    end else if (gGrp == `PAM_GRP_GPIOCFG || gGrp == `PAM_GRP_GPIODAT) begin
                        // gpio data lands in the register of the requesting master
                        gpioBus.wrEn  = gWr;
                        gpioBus.wrMap = (gGrp == `PAM_GRP_GPIOCFG); // RULE5
                        gpioBus.wrCla = (gM == PAM_CLA); // RULE3
                        if (gPost) begin
                            postValid_d = 1'b0;
                        end else begin
                            done_d[gM] = 1'b1;
                            st_d       = PAM_RESP;
                            if (gWr) begin
                                rdata_d = '0;
                            end else if (gGrp == `PAM_GRP_GPIOCFG) begin
                                rdata_d = gpioBus.mapRd;
                            end else begin
                                rdata_d = (gM == PAM_CLA) ? gpioBus.claRd : gpioBus.cpuRd;
                            end
                        end
                    end else begin
                        tReq_d    = 1'b1;
                        tWr_d     = gWr;
                        tAddr_d   = gAddr;
                        tData_d   = gData;
                        tMst_d    = gM;
                        postSel_d = gPost;
                        st_d      = PAM_ISSUE;
                    end
                end
            end
            PAM_ISSUE: begin
                if (tgtAccept) begin
                    tReq_d = 1'b0;
                    if (postSel_q) begin
                        postValid_d = 1'b0; // RULE9
                        st_d        = PAM_IDLE;
                    end else begin
                        done_d[tMst_q] = 1'b1;
                        rdata_d        = tWr_q ? '0 : tgtRdata;
                        st_d           = PAM_RESP;
                    end
                end
            end
            PAM_RESP: begin
                st_d = PAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_q        <= PAM_IDLE;
            done_q      <= 3'h0;
            denied_q    <= 1'b0;
            rdata_q     <= '0;
            tReq_q      <= 1'b0;
            tWr_q       <= 1'b0;
            tAddr_q     <= '0;
            tData_q     <= '0;
            tMst_q      <= PAM_CPU;
            postSel_q   <= 1'b0;
            postValid_q <= 1'b0;
            postAddr_q  <= '0;
            postData_q  <= '0;
            trig_q      <= '0;
        end else begin
            st_q        <= st_d;
            done_q      <= done_d;
            denied_q    <= denied_d;
            rdata_q     <= rdata_d;
            tReq_q      <= tReq_d;
            tWr_q       <= tWr_d;
            tAddr_q     <= tAddr_d;
            tData_q     <= tData_d;
            tMst_q      <= tMst_d;
            postSel_q   <= postSel_d;
            postValid_q <= postValid_d;
            postAddr_q  <= postAddr_d;
            postData_q  <= postData_d;
            trig_q      <= trig_d;
        end
    end

    pam_gpio gpioBlk (
        .sys_clk  (sys_clk),
        .rstnSync (rstnSync),
        .bus      (gpioBus),
        .gpioOut  (gpioOut)
    );

    assign cpuDone    = done_q[PAM_CPU];
    assign claDone    = done_q[PAM_CLA];
    assign dmaDone    = done_q[PAM_DMA];
    assign respDenied = denied_q;
    assign respRdata  = rdata_q;
    assign tgtReq     = tReq_q;
    assign tgtWrite   = tWr_q;
    assign tgtAddr    = tAddr_q;
    assign tgtWdata   = tData_q;
    assign tgtMaster  = tMst_q;
    assign dmaTrig    = trig_q;
endmodule

// ==== peripheral_access_matrix_asserts.sv ====
// port-level assertions for the access matrix
`timescale 1ns/100ps
`include "pam_defs.svh"
module peripheral_access_matrix_asserts
    import pam_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        frame1ToDma,
    input wire logic        frame2ToDma,
    input wire logic [15:0] claAddr,
    input wire logic [15:0] dmaAddr,
    input wire logic        cpuDone,
    input wire logic        claDone,
    input wire logic        dmaDone,
    input wire logic        respDenied,
    input wire logic [31:0] respRdata,
    input wire logic        tgtReq,
    input wire logic        tgtWrite,
    input wire logic [15:0] tgtAddr,
    input pam_master_t      tgtMaster,
    input wire logic        tgtAccept,
    input wire logic [31:0] tgtRdata,
    input wire logic [7:0]  periphTrig,
    input wire logic [7:0]  dmaTrig
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic [4:0] tGrp = tgtAddr[15:11];
    sequence sClaRead;
        tgtReq && tgtAccept && !tgtWrite && tgtMaster == PAM_CLA;
    endsequence
    sequence sClaAnswer;
        claDone && respRdata == $past(tgtRdata);
    endsequence
    a_trig_mask: assert property (dmaTrig == ($past(periphTrig) & 8'hc3))
        else $error("dma trigger not masked copy of events");
    a_deny_zero: assert property (respDenied |-> respRdata == 32'h0
        && (cpuDone || claDone || dmaDone)) else $error("denial without done or with data");
    a_cla_cfg_denied: assert property (claDone && claAddr[15:11] inside
        {[5'h02:5'h04], [5'h06:5'h10], [5'h13:5'h1f]} |-> respDenied)
        else $error("cla reached a main cpu group");
    a_dma_cfg_denied: assert property (dmaDone && dmaAddr[15:11] inside
        {[5'h02:5'h05], [5'h07:5'h11], [5'h13:5'h1f]} |-> respDenied)
        else $error("dma reached a main cpu group");
    a_cla_no_issue: assert property (tgtReq && tgtMaster == PAM_CLA
        |-> tGrp inside {5'h00, 5'h01, 5'h05, 5'h12}) else $error("cla issued to wrong group");
    a_dma_no_issue: assert property (tgtReq && tgtMaster == PAM_DMA
        |-> tGrp inside {5'h00, 5'h01, 5'h06, 5'h12}) else $error("dma issued to wrong group");
    a_frame_owner: assert property (tgtReq && tGrp < 5'h02 && tgtMaster != PAM_CPU
        |-> (tgtMaster == PAM_DMA) == (tGrp[0] ? frame2ToDma : frame1ToDma))
        else $error("frame issued to unselected master");
    a_cla_result: assert property (sClaRead |=> sClaAnswer)
        else $error("cla read not answered with target data");
    a_tgt_hold: assert property (tgtReq && !tgtAccept |=> tgtReq && $stable(tgtAddr))
        else $error("target request dropped before accept");
    a_tgt_drop: assert property (tgtReq && tgtAccept |=> !tgtReq)
        else $error("target request held after accept");
endmodule
bind peripheral_access_matrix peripheral_access_matrix_asserts u_asserts (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .frame1ToDma (frame1ToDma),
    .frame2ToDma (frame2ToDma),
    .claAddr     (claAddr),
    .dmaAddr     (dmaAddr),
    .cpuDone     (cpuDone),
    .claDone     (claDone),
    .dmaDone     (dmaDone),
    .respDenied  (respDenied),
    .respRdata   (respRdata),
    .tgtReq      (tgtReq),
    .tgtWrite    (tgtWrite),
    .tgtAddr     (tgtAddr),
    .tgtMaster   (tgtMaster),
    .tgtAccept   (tgtAccept),
    .tgtRdata    (tgtRdata),
    .periphTrig  (periphTrig),
    .dmaTrig     (dmaTrig)
);

// ==== pam_target_model.sv ====
// behavioural peripheral target with selectable accept delay
`timescale 1ns/100ps
module pam_target_model (
    input  wire logic        sys_clk,
    input  wire logic        tgtReq,
    input  wire logic        tgtWrite,
    input  wire logic [15:0] tgtAddr,
    input  wire logic [31:0] tgtWdata,
    input  wire logic [3:0]  slowWait,
    output logic             tgtAccept,
    output logic [31:0]      tgtRdata
);
    logic [31:0] mem [64];
    int          waitCnt = 0;
    initial tgtAccept = 1'b0;
    initial tgtRdata = 32'h0;
    always @(posedge sys_clk) begin
        tgtAccept <= 1'b0;
        // idle data toggles so a stale value never passes
        tgtRdata <= ~tgtRdata;
        if (tgtReq && !tgtAccept) begin
            if (waitCnt >= slowWait) begin
                waitCnt <= 0;
                tgtAccept <= 1'b1;
                if (tgtWrite)
                    mem[tgtAddr[5:0]] <= tgtWdata;
                else
                    tgtRdata <= mem[tgtAddr[5:0]];
            end else
                waitCnt <= waitCnt + 1;
        end
    end
endmodule

// ==== peripheral_access_matrix_bench.sv ====
// self-checking bench for the access matrix
`timescale 1ns/100ps
`include "pam_defs.svh"
module peripheral_access_matrix_bench;
    import pam_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        frame1ToDma = 1'b0;
    logic        frame2ToDma = 1'b1;
    logic [2:0]  req = 3'h0;
    logic [2:0]  wr = 3'h0;
    logic [15:0] addr [3] = '{default: 16'h0};
    logic [31:0] wd [3] = '{default: 32'h0};
    logic [7:0]  periphTrig = 8'h0;
    logic [3:0]  slowWait = 4'h0;
    wire  [2:0]  done;
    logic        tgtAccept, respDenied, tgtReq, tgtWrite;
    logic [31:0] tgtRdata, respRdata, tgtWdata, gpioOut;
    logic [15:0] tgtAddr;
    logic [7:0]  dmaTrig;
    pam_master_t tgtMaster;
    int          fails = 0;
    int          compares = 0;
    peripheral_access_matrix DUT (
        .sys_clk, .rstn, .frame1ToDma, .frame2ToDma,
        .cpuReq(req[0]), .cpuWrite(wr[0]), .cpuAddr(addr[0]), .cpuWdata(wd[0]),
        .claReq(req[1]), .claWrite(wr[1]), .claAddr(addr[1]), .claWdata(wd[1]),
        .dmaReq(req[2]), .dmaWrite(wr[2]), .dmaAddr(addr[2]), .dmaWdata(wd[2]),
        .cpuDone(done[0]), .claDone(done[1]), .dmaDone(done[2]),
        .respDenied, .respRdata, .tgtReq, .tgtWrite, .tgtAddr, .tgtWdata,
        .tgtMaster, .tgtAccept, .tgtRdata, .periphTrig, .dmaTrig, .gpioOut
    );
    pam_target_model u_target (
        .sys_clk, .tgtReq, .tgtWrite, .tgtAddr, .tgtWdata, .slowWait,
        .tgtAccept, .tgtRdata
    );
    initial forever #5 sys_clk = ~sys_clk;
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one whole access by master m, judged in its done cycle
    task automatic acc(int m, logic w, logic [15:0] a, logic [31:0] d,
                       logic den, logic [31:0] exp);
        int n;
        req[m] = 1'b1;
        wr[m] = w;
        addr[m] = a;
        wd[m] = d;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (done[m] !== 1'b1 && n < 60);
        if (n >= 60) begin
            fails++;
            complete_run();
        end
        check("denied", 32'(den), 32'(respDenied));
        check("rdata", exp, respRdata);
        req[m] = 1'b0;
        @(negedge sys_clk);
    endtask
    // permission table kept independently of the design
    function automatic logic ok(int m, logic [4:0] g);
        if (m == 0)
            return g <= 5'h12;
        if (g <= 5'h01)
            return (m == 2) == (g[0] ? frame2ToDma : frame1ToDma);
        if (m == 1)
            return g inside {5'h05, 5'h12};
        return g inside {5'h06, 5'h12};
    endfunction
    task automatic t_matrix(logic f1, logic f2, logic [3:0] sw);
        logic [31:0] last;
        logic [15:0] a;
        frame1ToDma = f1;
        frame2ToDma = f2;
        slowWait = sw;
        for (int g = 0; g < 21; g++) begin
            if (g == 9 || g == 17)
                continue;
            a = {5'(g), 11'(g)};
            last = 32'h0;
            for (int m = 0; m < 3; m++) begin
                acc(m, 1'b1, a, 32'(g * 256 + m), !ok(m, 5'(g)), 32'h0);
                if (ok(m, 5'(g)))
                    last = 32'(g * 256 + m);
            end
            acc(0, 1'b0, a, 32'h0, g > 18, last);
            if (ok(1, 5'(g)))
                acc(1, 1'b0, a, 32'h0, 1'b0, last);
        end
        $display("test matrix f1=%0d f2=%0d done", f1, f2);
    endtask
    task automatic t_order;
        // slow target keeps the posted write pending when the read arrives
        slowWait = 4'h6;
        acc(0, 1'b1, 16'h0030, 32'h5a5a_0030, 1'b0, 32'h0);
        acc(0, 1'b0, 16'h0030, 32'h0, 1'b0, 32'h5a5a_0030);
        $display("test order done");
    endtask
    task automatic t_gpio;
        acc(0, 1'b1, 16'h8800, 32'haaaa_5555, 1'b0, 32'h0);
        acc(1, 1'b1, 16'h8800, 32'h0f0f_f0f0, 1'b0, 32'h0);
        acc(2, 1'b1, 16'h8800, 32'hffff_ffff, 1'b1, 32'h0);
        acc(1, 1'b1, 16'h4800, 32'hffff_ffff, 1'b1, 32'h0);
        acc(2, 1'b1, 16'h4800, 32'hffff_ffff, 1'b1, 32'h0);
        repeat (3) @(negedge sys_clk);
        check("gpioOut", 32'haaaa_5555, gpioOut);
        acc(0, 1'b1, 16'h4800, 32'hffff_0000, 1'b0, 32'h0);
        repeat (3) @(negedge sys_clk);
        check("gpioOut", 32'h0f0f_5555, gpioOut);
        $display("test gpio done");
    endtask
    task automatic t_trig;
        for (int i = 0; i < 9; i++) begin
            periphTrig = (i < 8) ? 8'(1 << i) : 8'hff;
            repeat (2) @(negedge sys_clk);
            check("dmaTrig", 32'(periphTrig & 8'hc3), 32'(dmaTrig));
        end
        periphTrig = 8'h0;
        $display("test trig done");
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("gpioOut", 32'h0, gpioOut);
        check("tgtReq", 32'h0, 32'(tgtReq));
        t_matrix(1'b0, 1'b1, 4'h0);
        t_matrix(1'b1, 1'b0, 4'h3);
        t_order();
        t_gpio();
        t_trig();
        complete_run();
    end
endmodule
